//--- shared/aif_pkg.sv
// constants, field positions and state codes of the audio interrupt flag block
//
// How it works
// RQ1 - sticky flags clear on read, re-set on event
// RQ2 - adc sticky bit 6: signal below noise threshold
// RQ3 - adc sticky bits 4,3: record engine ports
// RQ4 - bit 2: dc measurement available, resets 0
// RQ5 - reserved adc bits 7,5,1,0 stay zero
// RQ6 - dac live bits 7,6: driver short circuits
// RQ7 - dac live bits 5,4: button, headset inserted
// RQ8 - dac live bits 3,2: compressor power above
// RQ9 - dac live bits 1,0: playback engine ports
// RQ10 - adc live bit 6: power below noise threshold
// RQ11 - adc live bits 4,3: record engine ports
// RQ12 - control bit 7 enables headset insertion source
// RQ13 - control bit 6 enables button press source
// RQ14 - control bit 5 enables compressor power source
// RQ15 - control bit 4 enables gain noise source
// RQ16 - control bit 3 enables short circuit source
// RQ17 - control bit 2 enables engine interrupt sources
// RQ18 - control bit 1 enables dc measurement source
// RQ19 - bit 0 low: one 2 ms pulse
// RQ20 - bit 0 high: pulse train until flags read
// RQ21 - dac sticky register holds latched playback events
// RQ22 - new enabled latched event starts pulse sequence
// RQ23 - pulse timing counted on the known clock
`default_nettype none

package aif_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_DAC_STICKY = 8'h2C;
    localparam logic [7:0] ADDR_ADC_STICKY = 8'h2D;
    localparam logic [7:0] ADDR_DAC_LIVE   = 8'h2E;
    localparam logic [7:0] ADDR_ADC_LIVE   = 8'h2F;
    localparam logic [7:0] ADDR_IRQ_CTRL   = 8'h30;
    localparam logic [7:0] ADDR_TOUCH_FLAG = 8'h32;

    // ----------------------------------------------------------------
    // reset values and masks
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam logic [7:0] FLAGS_RESET     = 8'h00;
    localparam logic [7:0] ADC_RSVD_MASK   = 8'hA3;

    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int EN_HEADSET = 7;
    localparam int EN_BUTTON  = 6;
    localparam int EN_DRC     = 5;
    localparam int EN_AGC     = 4;
    localparam int EN_SHORT   = 3;
    localparam int EN_ENGINE  = 2;
    localparam int EN_DCMEAS  = 1;
    localparam int TRAIN_MODE = 0;

    // ----------------------------------------------------------------
    // adc and dac flag fields and source vector layout
    // ----------------------------------------------------------------
    localparam int ADC_AGC_BIT  = 6;
    localparam int ADC_STD_BIT  = 4;
    localparam int ADC_AUX_BIT  = 3;
    localparam int ADC_DC_BIT   = 2;
    localparam int DAC_HS_BIT   = 4;
    localparam int SRC_W        = 12;
    localparam int SRC_DAC_LSB  = 4;
    localparam int SRC_HEADSET  = 8;
    localparam int SRC_AGC      = 3;
    localparam int SRC_ADC_STD  = 2;
    localparam int SRC_ADC_AUX  = 1;
    localparam int SRC_DC       = 0;

    // ----------------------------------------------------------------
    // pulse timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_KHZ            = 40000;
    localparam int unsigned PULSE_WIDTH_MS     = 2;
    localparam int unsigned PULSE_PERIOD_MS    = 4;
    localparam int unsigned PULSE_WIDTH_CYCLES = PULSE_WIDTH_MS * CLK_KHZ;
    localparam int unsigned PULSE_PERIOD_CYCLES = PULSE_PERIOD_MS * CLK_KHZ;
    localparam int          CNT_W              = 18;

    typedef enum logic [2:0] {
        AIF_IDLE = 3'b001,
        AIF_HIGH = 3'b010,
        AIF_LOW  = 3'b100
    } aif_state_e;

endpackage : aif_pkg

`default_nettype wire

//--- rtl/aif_pulse_gen.sv
// single pulse or pulse train generator for the first interrupt pin
`default_nettype none

module aif_pulse_gen
    import aif_pkg::*;
#(
    parameter int unsigned WIDTH_CYCLES  = PULSE_WIDTH_CYCLES,
    parameter int unsigned PERIOD_CYCLES = PULSE_PERIOD_CYCLES
)(
    // clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // control
    input  wire logic start,
    input  wire logic train,
    input  wire logic stop,
    // pin
    output logic      pin
);

    localparam logic [CNT_W-1:0] HIGH_LAST = CNT_W'(WIDTH_CYCLES - 1);
    localparam logic [CNT_W-1:0] LOW_LAST  = CNT_W'(PERIOD_CYCLES - WIDTH_CYCLES - 1);

    aif_state_e       state;
    aif_state_e       next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_cnt   = cnt + 1'b1;
        case (state)
            AIF_IDLE:
            begin
                next_cnt = '0;
            end
            AIF_HIGH:
            begin
                if (cnt == HIGH_LAST)                               // [RQ23]
                begin
                    next_cnt   = '0;
                    next_state = (train && !stop) ? AIF_LOW : AIF_IDLE;  // [RQ19] [RQ20]
                end
            end
            AIF_LOW:
            begin
                if (cnt == LOW_LAST)                                // [RQ23]
                begin
                    next_cnt   = '0;
                    next_state = (train && !stop) ? AIF_HIGH : AIF_IDLE; // [RQ20]
                end
            end
            default:
            begin
                next_state = AIF_IDLE;
                next_cnt   = '0;
            end
        endcase
        // a fresh event restarts the sequence even mid-pulse
        if (start)                                                  // [RQ22]
        begin
            next_state = AIF_HIGH;
            next_cnt   = '0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            state <= AIF_IDLE;
            cnt   <= '0;
            pin   <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt   <= next_cnt;
            pin   <= (next_state == AIF_HIGH);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_start_high: assert property (@(posedge clock) disable iff (!rstn) // [RQ22]
        start |=> pin && (cnt == '0))
        else $error("start did not raise the pin");
    chk_width_bound: assert property (@(posedge clock) disable iff (!rstn) // [RQ23]
        pin |-> (state == AIF_HIGH) && (cnt <= HIGH_LAST))
        else $error("pin high beyond pulse width");
    chk_single_end: assert property (@(posedge clock) disable iff (!rstn) // [RQ19]
        (state == AIF_HIGH && cnt == HIGH_LAST && !train && !start) |=> !pin && state == AIF_IDLE)
        else $error("single pulse did not end");
    chk_train_low: assert property (@(posedge clock) disable iff (!rstn) // [RQ20]
        (state == AIF_HIGH && cnt == HIGH_LAST && train && !stop && !start)
        |=> state == AIF_LOW)
        else $error("train did not enter low phase");

endmodule : aif_pulse_gen

`default_nettype wire

//--- rtl/aif_top.sv
// audio interrupt flag registers and first interrupt pin generation
`default_nettype none

module aif_top
    import aif_pkg::*;
#(
    parameter int unsigned WIDTH_CYCLES  = PULSE_WIDTH_CYCLES,
    parameter int unsigned PERIOD_CYCLES = PULSE_PERIOD_CYCLES
)(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // register port from the control interface
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // playback side event sources
    input  wire logic       short_left,
    input  wire logic       short_right,
    input  wire logic       button_pressed,
    input  wire logic       headset_inserted,
    input  wire logic       drc_left_above,
    input  wire logic       drc_right_above,
    input  wire logic       dac_engine_std,
    input  wire logic       dac_engine_aux,
    // record side event sources
    input  wire logic       agc_noise_below,
    input  wire logic       adc_engine_std,
    input  wire logic       adc_engine_aux,
    input  wire logic       dc_meas_avail,
    // interrupt pin
    output logic            first_interrupt_pin
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] adc_layout(input logic automatic_gain_control, input logic std,
                                              input logic aux, input logic dc);
        logic [7:0] v;
        v              = FLAGS_RESET;
        v[ADC_AGC_BIT] = automatic_gain_control;
        v[ADC_STD_BIT] = std;
        v[ADC_AUX_BIT] = aux;
        v[ADC_DC_BIT]  = dc;
        return v;
    endfunction : adc_layout

    function automatic logic reg_hit(input logic strobe, input logic [7:0] addr,
                                     input logic [7:0] target);
        return strobe && (addr == target);
    endfunction : reg_hit

    // ----------------------------------------------------------------
    // source synchronisers
    // ----------------------------------------------------------------
    logic [SRC_W-1:0] src_raw;
    logic [SRC_W-1:0] src_meta;
    logic [SRC_W-1:0] src_sync;
    logic [SRC_W-1:0] src_prev;

    assign src_raw = {short_left, short_right, button_pressed, headset_inserted,
                      drc_left_above, drc_right_above, dac_engine_std, dac_engine_aux,
                      agc_noise_below, adc_engine_std, adc_engine_aux, dc_meas_avail};

    // detectors sit in the analog and engine domains, so every source is resynced
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            src_meta <= '0;
            src_sync <= '0;
            src_prev <= '0;
        end
        else
        begin
            src_meta <= src_raw;
            src_sync <= src_meta;
            src_prev <= src_sync;
        end
    end

    // ----------------------------------------------------------------
    // live views
    // ----------------------------------------------------------------
    logic [7:0] dac_live;
    logic [7:0] adc_live;
    logic       dc_rise;

    assign dac_live = src_sync[SRC_W-1:SRC_DAC_LSB];   // [RQ6] [RQ7] [RQ8] [RQ9]
    assign adc_live = adc_layout(src_sync[SRC_AGC],     // [RQ10] [RQ11] [RQ4]
                                 src_sync[SRC_ADC_STD],
                                 src_sync[SRC_ADC_AUX],
                                 src_sync[SRC_DC]);
    assign dc_rise  = src_sync[SRC_DC] && !src_prev[SRC_DC];

    // ----------------------------------------------------------------
    // register strobes
    // ----------------------------------------------------------------
    logic rd_dac_sticky;
    logic rd_adc_sticky;
    logic rd_touch;
    logic wr_ctrl;

    assign rd_dac_sticky = reg_hit(reg_rd, reg_addr, ADDR_DAC_STICKY);
    assign rd_adc_sticky = reg_hit(reg_rd, reg_addr, ADDR_ADC_STICKY);
    assign rd_touch      = reg_hit(reg_rd, reg_addr, ADDR_TOUCH_FLAG);
    assign wr_ctrl       = reg_hit(reg_wr, reg_addr, ADDR_IRQ_CTRL);

    // ----------------------------------------------------------------
    // sticky flags
    // ----------------------------------------------------------------
    logic [7:0] dac_sticky;
    logic [7:0] adc_sticky;
    logic [7:0] dac_set;
    logic [7:0] adc_set;
    logic [7:0] next_dac_sticky;
    logic [7:0] next_adc_sticky;

    always_comb
    begin
        dac_set             = src_sync[SRC_W-1:SRC_DAC_LSB];          // [RQ21]
        // headset sticky marks any insertion or removal, not the level
        dac_set[DAC_HS_BIT] = src_sync[SRC_HEADSET] ^ src_prev[SRC_HEADSET];
        // dc availability is a live bit, so it is kept out of the sticky copy
        adc_set             = adc_layout(src_sync[SRC_AGC],          // [RQ2] [RQ3]
                                         src_sync[SRC_ADC_STD],
                                         src_sync[SRC_ADC_AUX],
                                         1'b0);
        // set wins over the clear of a read in the same cycle
        next_dac_sticky     = (rd_dac_sticky ? FLAGS_RESET : dac_sticky) | dac_set; // [RQ1]
        next_adc_sticky     = (rd_adc_sticky ? FLAGS_RESET : adc_sticky) | adc_set; // [RQ1]
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            dac_sticky <= FLAGS_RESET;
            adc_sticky <= FLAGS_RESET;                                // [RQ5]
        end
        else
        begin
            dac_sticky <= next_dac_sticky;
            adc_sticky <= next_adc_sticky;
        end
    end

    // ----------------------------------------------------------------
    // source enables
    // ----------------------------------------------------------------
    logic [7:0] ctrl;

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            ctrl <= CTRL_RESET;
        end
        else if (wr_ctrl)
        begin
            ctrl <= reg_wdata;                                        // [RQ12]
        end
    end

    logic [7:0] dac_mask;
    logic [7:0] adc_mask;
    logic       start_evt;

    always_comb
    begin
        dac_mask = {ctrl[EN_SHORT], ctrl[EN_SHORT],                   // [RQ16]
                    ctrl[EN_BUTTON],                                  // [RQ13]
                    ctrl[EN_HEADSET],                                 // [RQ12]
                    ctrl[EN_DRC], ctrl[EN_DRC],                       // [RQ14]
                    ctrl[EN_ENGINE], ctrl[EN_ENGINE]};                // [RQ17]
        adc_mask = adc_layout(ctrl[EN_AGC],                           // [RQ15]
                              ctrl[EN_ENGINE], ctrl[EN_ENGINE],       // [RQ17]
                              1'b0);
        // only a flag that turns on starts a sequence, not one already held
        start_evt = |(dac_set & ~dac_sticky & dac_mask)               // [RQ22]
                  | |(adc_set & ~adc_sticky & adc_mask)
                  | (dc_rise && ctrl[EN_DCMEAS]);                     // [RQ18]
    end

    // ----------------------------------------------------------------
    // read tracking for the pulse train
    // ----------------------------------------------------------------
    logic [2:0] read_seen;

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            read_seen <= 3'h0;
        end
        else if (start_evt)
        begin
            read_seen <= 3'h0;
        end
        else
        begin
            read_seen <= read_seen | {rd_touch, rd_adc_sticky, rd_dac_sticky}; // [RQ20]
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            reg_rdata <= FLAGS_RESET;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                ADDR_DAC_STICKY: reg_rdata <= dac_sticky;
                ADDR_ADC_STICKY: reg_rdata <= adc_sticky | adc_layout(1'b0, 1'b0, 1'b0,
                                                                      src_sync[SRC_DC]); // [RQ4]
                ADDR_DAC_LIVE:   reg_rdata <= dac_live;
                ADDR_ADC_LIVE:   reg_rdata <= adc_live;
                ADDR_IRQ_CTRL:   reg_rdata <= ctrl;
                // touch flags live elsewhere; this block only notes the read
                default:         reg_rdata <= FLAGS_RESET;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin generation
    // ----------------------------------------------------------------
    aif_pulse_gen #(
        .WIDTH_CYCLES  (WIDTH_CYCLES),
        .PERIOD_CYCLES (PERIOD_CYCLES)
    ) u_pulse (
        .clock (clock),
        .rstn  (rstn),
        .start (start_evt),
        .train (ctrl[TRAIN_MODE]),                                    // [RQ19] [RQ20]
        .stop  (&read_seen),
        .pin   (first_interrupt_pin)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_sticky_clear: assert property (@(posedge clock) disable iff (!rstn) // [RQ1]
        (rd_dac_sticky && dac_set == 8'h00) |=> dac_sticky == 8'h00)
        else $error("sticky flags not cleared by read");
    chk_sticky_latch: assert property (@(posedge clock) disable iff (!rstn) // [RQ21]
        (src_sync[SRC_W-1] && !$past(src_sync[SRC_W-1])) |=> dac_sticky[7] [*2])
        else $error("short circuit not latched");
    chk_agc_sticky: assert property (@(posedge clock) disable iff (!rstn) // [RQ2]
        src_sync[SRC_AGC] |=> adc_sticky[ADC_AGC_BIT])
        else $error("noise flag not latched");
    chk_adc_eng_sticky: assert property (@(posedge clock) disable iff (!rstn) // [RQ3]
        (src_sync[SRC_ADC_STD] && !rd_adc_sticky)
        ##1 (!src_sync[SRC_ADC_STD] && !rd_adc_sticky)
        ##1 !src_sync[SRC_ADC_STD] |-> adc_sticky[ADC_STD_BIT])
        else $error("record engine flag lost before read");
    chk_dc_bit: assert property (@(posedge clock) disable iff (!rstn) // [RQ4]
        reg_hit(reg_rd, reg_addr, ADDR_ADC_LIVE)
        |=> reg_rdata[ADC_DC_BIT] == $past(src_sync[SRC_DC]))
        else $error("dc availability misreported");
    chk_reserved_zero: assert property (@(posedge clock) disable iff (!rstn) // [RQ5]
        (reg_rd && (reg_addr == ADDR_ADC_STICKY || reg_addr == ADDR_ADC_LIVE))
        |=> (reg_rdata & ADC_RSVD_MASK) == 8'h00)
        else $error("reserved adc bits nonzero");
    chk_short_live: assert property (@(posedge clock) disable iff (!rstn) // [RQ6]
        reg_hit(reg_rd, reg_addr, ADDR_DAC_LIVE) |=> reg_rdata[7:6] == $past(src_sync[11:10]))
        else $error("short circuit live bits wrong");
    chk_headset_live: assert property (@(posedge clock) disable iff (!rstn) // [RQ7]
        reg_hit(reg_rd, reg_addr, ADDR_DAC_LIVE) |=> reg_rdata[5:4] == $past(src_sync[9:8]))
        else $error("headset live bits wrong");
    chk_drc_live: assert property (@(posedge clock) disable iff (!rstn) // [RQ8]
        reg_hit(reg_rd, reg_addr, ADDR_DAC_LIVE) |=> reg_rdata[3:2] == $past(src_sync[7:6]))
        else $error("compressor live bits wrong");
    chk_dac_eng_live: assert property (@(posedge clock) disable iff (!rstn) // [RQ9]
        reg_hit(reg_rd, reg_addr, ADDR_DAC_LIVE) |=> reg_rdata[1:0] == $past(src_sync[5:4]))
        else $error("playback engine live bits wrong");
    chk_agc_live: assert property (@(posedge clock) disable iff (!rstn) // [RQ10]
        reg_hit(reg_rd, reg_addr, ADDR_ADC_LIVE)
        |=> reg_rdata[ADC_AGC_BIT] == $past(src_sync[SRC_AGC]))
        else $error("noise live bit wrong");
    chk_adc_eng_live: assert property (@(posedge clock) disable iff (!rstn) // [RQ11]
        reg_hit(reg_rd, reg_addr, ADDR_ADC_LIVE) |=> reg_rdata[4:3] == $past(src_sync[2:1]))
        else $error("record engine live bits wrong");
    chk_ctrl_write: assert property (@(posedge clock) disable iff (!rstn) // [RQ12]
        wr_ctrl |=> ctrl == $past(reg_wdata))
        else $error("control write not stored");
    chk_start_gate: assert property (@(posedge clock) disable iff (!rstn) // [RQ22]
        (ctrl[7:1] == 7'h00) |-> !start_evt)
        else $error("pulse started with all sources disabled");
    chk_train_stop: assert property (@(posedge clock) disable iff (!rstn) // [RQ20]
        (!start_evt && rd_dac_sticky && read_seen[2:1] == 2'b11) |=> &read_seen)
        else $error("flag reads not recorded");

endmodule : aif_top

`default_nettype wire

//--- dv/aif_host_model.sv
// host side model: drives the register port and receives the pin
`default_nettype none

module aif_host_model
(
    // clock
    input  wire logic       clock,
    // register port
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    // pin
    input  wire logic       first_interrupt_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // only the control register is ever written, so flag bits see no data
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic wr);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = wr;
        reg_rd    = !wr;
        @(posedge clock);
        #2;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        // released lines show garbage, not the last value
        reg_addr  = ~a;
        reg_wdata = ~d;
        @(posedge clock);
        #2;
    endtask : access
endmodule : aif_host_model

`default_nettype wire

//--- dv/test_aif_top.sv
// self-checking bench for the audio interrupt flag block
`default_nettype none

module test_aif_top
    import aif_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int W = 4;
    localparam int P = 8;
    logic        clock;
    logic        rstn;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
    logic        reg_wr, reg_rd, rd_q, pin;
    logic [11:0] src, s;
    logic [15:0] notes[$];
    logic [15:0] note;
    int          mismatches, samples_checked, seed;
    int          en_tab[8] = '{EN_HEADSET, EN_BUTTON, EN_DRC, EN_AGC, EN_SHORT, EN_ENGINE,
                               EN_ENGINE, EN_DCMEAS};
    int          src_tab[8] = '{SRC_HEADSET, 9, 7, SRC_AGC, 11, 5, SRC_ADC_STD, SRC_DC};

    aif_top #(.WIDTH_CYCLES(W), .PERIOD_CYCLES(P)) DUT (.clock(clock), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .short_left(src[11]), .short_right(src[10]),
        .button_pressed(src[9]), .headset_inserted(src[8]), .drc_left_above(src[7]),
        .drc_right_above(src[6]), .dac_engine_std(src[5]), .dac_engine_aux(src[4]),
        .agc_noise_below(src[3]), .adc_engine_std(src[2]), .adc_engine_aux(src[1]),
        .dc_meas_avail(src[0]), .first_interrupt_pin(pin));
    aif_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .first_interrupt_pin(pin));

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic check_read(input logic [7:0] got, input logic [15:0] n);
        samples_checked++;
        if ((got & n[15:8]) !== (n[7:0] & n[15:8]))
        begin
            mismatches++;
            $display("Error at %0t: read %h, expected %h", $time, got, n[7:0]);
        end
    endtask : check_read

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        notes.push_back({m, e});
        host.access(a, 8'h00, 1'b0);
    endtask : rd

    // counts rises and high cycles of the pin; exp_hi below zero skips widths
    task automatic check_pin(input int cycles, input int exp_r, input int exp_hi);
        logic last;
        int   r;
        int   hi;
        last = pin;
        r = 0;
        hi = 0;
        repeat (cycles)
        begin
            @(negedge clock);
            r += int'(pin === 1'b1 && last !== 1'b1);
            hi += int'(pin === 1'b1);
            last = pin;
        end
        @(posedge clock);
        #2;
        samples_checked++;
        if (r != exp_r || (exp_hi >= 0 && hi != exp_hi))
        begin
            mismatches++;
            $display("Error at %0t: pin rose %0d high %0d", $time, r, hi);
        end
    endtask : check_pin

    // read data lands one edge after the strobe is taken
    always @(posedge clock)
    begin
        if (rd_q === 1'b1)
        begin
            note = notes.pop_front();
            check_read(reg_rdata, note);
        end
        rd_q <= reg_rd;
    end

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial
    begin
        #500us;
        mismatches++;
        finish_test();
    end

    initial
    begin
        seed = 32'h8CED;
        mismatches = 0;
        samples_checked = 0;
        rd_q = 1'b0;
        src = '0;
        rstn = 1'b0;
        repeat (5) @(posedge clock);
        #2;
        rstn = 1'b1;
        rd(ADDR_DAC_STICKY, 8'h00, 8'hFF);
        rd(ADDR_ADC_STICKY, 8'h00, 8'hFF);
        rd(ADDR_DAC_LIVE, 8'h00, 8'hFF);
        rd(ADDR_ADC_LIVE, 8'h00, 8'hFF);
        rd(ADDR_IRQ_CTRL, 8'h00, 8'hFF);
        rd(ADDR_TOUCH_FLAG, 8'h00, 8'hFF);
        v = 8'($random(seed));
        host.access(ADDR_IRQ_CTRL, v, 1'b1);
        rd(ADDR_IRQ_CTRL, v, 8'hFF);
        src = 12'($random(seed));
        s = src;
        repeat (4) @(posedge clock);
        #2;
        rd(ADDR_DAC_LIVE, s[11:4], 8'hFF);
        rd(ADDR_ADC_LIVE, {1'b0, s[3], 1'b0, s[2:0], 2'b00}, 8'hFF);
        src = '0;
        repeat (4) @(posedge clock);
        #2;
        rd(ADDR_DAC_STICKY, s[11:4], 8'hFF);
        rd(ADDR_ADC_STICKY, {1'b0, s[3], 1'b0, s[2:1], 3'b000}, 8'hFF);
        rd(ADDR_DAC_STICKY, 8'h00, 8'hFF);
        rd(ADDR_ADC_STICKY, 8'h00, 8'hFF);
        for (int i = 0; i < 16; i++)
        begin
            v = 8'h01 << en_tab[i % 8];
            host.access(ADDR_IRQ_CTRL, (i < 8) ? v : 8'hFE & ~v, 1'b1);
            // stickies still hold the previous pass's source, except dc availability, until these reads
            s = (i == 0) ? 12'h000 : 12'h001 << src_tab[(i + 7) % 8];
            rd(ADDR_DAC_STICKY, s[11:4], 8'hFF);
            rd(ADDR_ADC_STICKY, {1'b0, s[3], 1'b0, s[2:1], 3'b000}, 8'hFF);
            src[src_tab[i % 8]] = 1'b1;
            repeat (2) @(posedge clock);
            #2;
            src = '0;
            check_pin(24, int'(i < 8), (i < 8) ? W : 0);
        end
        host.access(ADDR_IRQ_CTRL, 8'h09, 1'b1);
        src[11] = 1'b1;
        repeat (2) @(posedge clock);
        #2;
        src = '0;
        check_pin(30, 4, -1);
        rd(ADDR_DAC_STICKY, 8'h80, 8'hFF);
        rd(ADDR_ADC_STICKY, 8'h00, 8'hFF);
        rd(ADDR_TOUCH_FLAG, 8'h00, 8'hFF);
        repeat (16) @(posedge clock);
        #2;
        check_pin(24, 0, 0);
        finish_test();
    end
endmodule : test_aif_top

`default_nettype wire
